// File: design/bel_pkg.sv
// constants, field positions, register offsets and the bus-init state type for the bus error logger.
// assumes a single core clock pclk; bus clock is derived inside the block from a programmed ratio.
// Operation
// - bit 29 set whenever this device drives the bus error output.
// - bit 30 set when this processor itself drives the bus init signal.
// - bit 35 set when bus init is received from another agent.
// - check three response status lines against response parity; mismatch sets bit 36.
// - bit 37 set on hard error response to a split access.
// - bit 38 set when the retirement watchdog expires.
// - watchdog is a 15-bit up-counter; expiry is carry out of its top bit.
// - counter clears on retire, core exception, reset or watchdog-driven bus init.
// - 8-bit prescaler on the bus clock divides by 128.
// - counter steps by one on each prescaler carry, never otherwise.
// - bus clock runs at one half, third or quarter of core clock.
// - watchdog expiry sets code bit 10, clears other code bits; needs driver enabled.
// - once timeout bit is set, later errors do not overwrite the log.
package bel_pkg;

  // widths
  localparam int unsigned PRE_W = 8;
  localparam int unsigned WDOG_W = 15;
  localparam int unsigned EV_W = 6;
  localparam int unsigned ADDR_W = 12;

  // watchdog defaults
  localparam int unsigned PRESCALE_DIV_DEF = 128;
  localparam int unsigned WDOG_LIMIT_DEF = 32768;

  // register byte offsets
  localparam logic [11:0] OFF_STATUS_LO = 12'h000;
  localparam logic [11:0] OFF_STATUS_HI = 12'h004;
  localparam logic [11:0] OFF_CTRL = 12'h008;
  localparam logic [11:0] OFF_WDOG = 12'h00c;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h010;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h014;

  // positions inside the 64-bit machine check bank status
  localparam int unsigned ST_CODE_WDOG = 10;
  localparam int unsigned ST_CODE_EBL = 11;
  localparam int unsigned ST_BUS_ERROR_OUT = 29;
  localparam int unsigned ST_BUS_INIT_SIGNAL_DRV = 30;
  localparam int unsigned ST_BUS_INIT_SIGNAL_RX = 35;
  localparam int unsigned ST_RESP_PAR = 36;
  localparam int unsigned ST_SPLIT_HARD = 37;
  localparam int unsigned ST_TIMEOUT = 38;
  localparam logic [63:0] STATUS_RESET = 64'h0;

  // event indices, shared by the interrupt status and mask registers
  localparam int unsigned EV_BUS_ERROR_OUT = 0;
  localparam int unsigned EV_BUS_INIT_SIGNAL_DRV = 1;
  localparam int unsigned EV_BUS_INIT_SIGNAL_RX = 2;
  localparam int unsigned EV_RESP_PAR = 3;
  localparam int unsigned EV_SPLIT_HARD = 4;
  localparam int unsigned EV_TIMEOUT = 5;

  // control register fields
  localparam int unsigned CTRL_RATIO_LSB = 0;
  localparam int unsigned CTRL_BUS_INIT_SIGNAL_EN = 2;
  localparam int unsigned CTRL_CLEAR = 3;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // response code that marks a hard failure
  localparam logic [2:0] RS_HARD_ERR = 3'h1;

  // cycles our own bus init drive takes to clear the input synchroniser
  localparam logic [1:0] ECHO_CYCLES = 2'h3;

  typedef enum logic [1:0] {
    BI_IDLE = 2'b00,
    BI_DRIVE = 2'b01,
    BI_ECHO = 2'b10
  } bel_bus_init_signal_state_t;

  // core-to-bus ratio code: 0 is 1:2, 1 is 1:3, 2 and 3 are 1:4
  function automatic logic [2:0] bel_ratio_div(input logic [1:0] code);
    bel_ratio_div = (code == 2'h0) ? 3'h2 : ((code == 2'h1) ? 3'h3 : 3'h4);
  endfunction

endpackage

// File: design/bel_sync.sv
// two flip-flop synchroniser for a group of pins.
// assumes the pins are quasi-static relative to pclk over at least two cycles.
`timescale 1ns/1ps
module bel_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pin side and synchronised side
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage is read only by the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // bel_sync

// File: design/bel_watchdog.sv
// retirement watchdog: prescaler on bus clock ticks feeding a wide counter.
// assumes bus_tick is a one-cycle pulse per bus clock period on pclk.
`timescale 1ns/1ps
module bel_watchdog
  import bel_pkg::*;
#(
  parameter int unsigned PRESCALE_DIV = bel_pkg::PRESCALE_DIV_DEF,
  parameter int unsigned WDOG_LIMIT = bel_pkg::WDOG_LIMIT_DEF
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic bus_tick,
  input wire logic clear,
  input wire logic enable,
  // state
  output logic [bel_pkg::WDOG_W-1:0] count,
  output logic expire
);

  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRESCALE_DIV - 1);
  localparam logic [WDOG_W-1:0] CNT_LAST = WDOG_W'(WDOG_LIMIT - 1);

  logic [PRE_W-1:0] pre_q;
  logic [PRE_W-1:0] pre_d;
  logic [WDOG_W-1:0] cnt_q;
  logic [WDOG_W-1:0] cnt_d;
  logic expire_q;
  logic pre_carry;
  logic cnt_carry;

  // prescaler wraps after PRESCALE_DIV bus clocks
  assign pre_carry = bus_tick & (pre_q == PRE_LAST);
  assign pre_d = clear ? '0 : (pre_carry ? '0 : (bus_tick ? pre_q + 1'b1 : pre_q));
  // counter steps only on a prescaler carry; the carry that steps it past WDOG_LIMIT - 1 is expiry
  assign cnt_carry = pre_carry & (cnt_q == CNT_LAST);
  assign cnt_d = clear ? '0 : (pre_carry ? cnt_q + 1'b1 : cnt_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= '0;
      cnt_q <= '0;
      expire_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      expire_q <= cnt_carry & enable & ~clear;
    end
  end

  assign count = cnt_q;
  assign expire = expire_q;

endmodule // bel_watchdog

// File: design/bel_top.sv
// bus error status logger: upper machine check status bits, retirement watchdog, apb registers.
// assumes core-side requests are synchronous to pclk and bus pins are asynchronous.
`timescale 1ns/1ps
module bel_top
  import bel_pkg::*;
#(
  parameter int unsigned PRESCALE_DIV = bel_pkg::PRESCALE_DIV_DEF,
  parameter int unsigned WDOG_LIMIT = bel_pkg::WDOG_LIMIT_DEF
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [bel_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core side
  input wire logic uop_retire,
  input wire logic core_exception,
  input wire logic bus_error_out_req,
  input wire logic bus_init_signal_req,
  input wire logic split_access,
  // external bus pins
  input wire logic bus_init_in,
  output logic bus_init_out,
  output logic bus_init_oe_n,
  output logic bus_error_out,
  input wire logic response_valid_in,
  input wire logic [2:0] response_status_in,
  input wire logic response_parity_in,
  // interrupt
  output logic irq
);

  // synchronised pins
  logic [5:0] pins_sync;
  logic bus_init_s;
  logic resp_valid_s;
  logic [2:0] resp_status_s;
  logic resp_parity_s;

  // apb decode
  logic apb_setup;
  logic apb_access;
  logic apb_wr;
  logic apb_rd;
  logic hit_status_lo;
  logic hit_status_hi;
  logic hit_ctrl;
  logic hit_wdog;
  logic hit_irq_stat;
  logic hit_irq_mask;
  logic addr_ok;
  logic [31:0] rd_mux;

  // registers
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic [2:0] ctrl_q;
  logic [2:0] ctrl_d;
  logic [EV_W-1:0] irq_mask_q;
  logic [EV_W-1:0] irq_mask_d;
  logic [EV_W-1:0] irq_stat_q;
  logic [EV_W-1:0] irq_stat_d;
  logic [EV_W-1:0] irq_clr;
  logic [63:0] status_q;
  logic [63:0] status_d;
  logic [63:0] status_base;
  logic [63:0] status_set;
  logic log_clear;

  // bus clock divider
  logic [2:0] div_q;
  logic [2:0] div_d;
  logic [2:0] div_last;
  logic bus_tick;

  // bus init drive state
  bel_bus_init_signal_state_t bi_state_q;
  bel_bus_init_signal_state_t bi_state_d;
  logic [1:0] echo_q;
  logic [1:0] echo_d;
  logic drive_start;
  logic bus_error_q;
  logic bi_idle;
  logic bi_drive;

  // events and watchdog
  logic [EV_W-1:0] ev;
  logic ebl_event;
  logic par_err;
  logic split_hard;
  logic wd_clear;
  logic wd_expire;
  logic [WDOG_W-1:0] wd_count;

  // bus pins pass two flops before any logic sees them
  bel_sync #(
    .W(6)
  ) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({bus_init_in, response_valid_in, response_status_in, response_parity_in}),
    .sync_out(pins_sync)
  );

  assign bus_init_s = pins_sync[5];
  assign resp_valid_s = pins_sync[4];
  assign resp_status_s = pins_sync[3:1];
  assign resp_parity_s = pins_sync[0];

  // bus clock tick every 2, 3 or 4 core clocks as programmed
  assign div_last = bel_ratio_div(ctrl_q[CTRL_RATIO_LSB +: 2]) - 3'h1;
  assign bus_tick = (div_q >= div_last);
  assign div_d = bus_tick ? 3'h0 : div_q + 3'h1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_d;
    end
  end

  // watchdog restarts on retirement, exception or its own bus init
  assign wd_clear = uop_retire | core_exception | wd_expire;

  bel_watchdog #(
    .PRESCALE_DIV(PRESCALE_DIV),
    .WDOG_LIMIT(WDOG_LIMIT)
  ) u_watchdog (
    .pclk(pclk),
    .presetn(presetn),
    .bus_tick(bus_tick),
    .clear(wd_clear),
    .enable(ctrl_q[CTRL_BUS_INIT_SIGNAL_EN]),
    .count(wd_count),
    .expire(wd_expire)
  );

  // state decode shared by the pin drive and the foreign init filter
  assign bi_idle = (bi_state_q == BI_IDLE);
  assign bi_drive = (bi_state_q == BI_DRIVE);

  // bus init drive: hold while the core asks, then mask our own echo
  // the echo window keeps our drive from being logged as a foreign init
  assign drive_start = bi_idle & (bus_init_signal_req | wd_expire);

  always_comb begin
    bi_state_d = bi_state_q;
    echo_d = echo_q;
    unique case (bi_state_q)
      BI_IDLE: begin
        if (drive_start) begin
          bi_state_d = BI_DRIVE;
        end
      end
      BI_DRIVE: begin
        if (!bus_init_signal_req) begin
          bi_state_d = BI_ECHO;
          echo_d = ECHO_CYCLES;
        end
      end
      BI_ECHO: begin
        if (bus_init_signal_req) begin
          bi_state_d = BI_DRIVE;
        end else if (echo_q == 2'h0) begin
          bi_state_d = BI_IDLE;
        end else begin
          echo_d = echo_q - 2'h1;
        end
      end
      default: begin
        bi_state_d = BI_IDLE;
      end
    endcase
  end

  // state register for the bus init drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bi_state_q <= BI_IDLE;
    end else begin
      bi_state_q <= bi_state_d;
    end
  end

  // echo window countdown after our own drive ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      echo_q <= 2'h0;
    end else begin
      echo_q <= echo_d;
    end
  end

  // bus error pin is the core request one cycle late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_error_q <= 1'b0;
    end else begin
      bus_error_q <= bus_error_out_req;
    end
  end

  assign bus_init_out = bi_drive;
  assign bus_init_oe_n = ~bi_drive;
  assign bus_error_out = bus_error_q;

  // even parity over three status lines and the parity line
  assign par_err = resp_valid_s & (^{resp_status_s, resp_parity_s});
  // split_access must be held by the core until the synchronised response
  assign split_hard = resp_valid_s & split_access & (resp_status_s == RS_HARD_ERR);

  // one event vector feeds both the log and the interrupt status
  assign ev[EV_BUS_ERROR_OUT] = bus_error_q;
  assign ev[EV_BUS_INIT_SIGNAL_DRV] = drive_start;
  assign ev[EV_BUS_INIT_SIGNAL_RX] = bus_init_s & bi_idle;
  assign ev[EV_RESP_PAR] = par_err;
  assign ev[EV_SPLIT_HARD] = split_hard;
  assign ev[EV_TIMEOUT] = wd_expire;
  assign ebl_event = |ev[EV_SPLIT_HARD:EV_BUS_ERROR_OUT];

  // set bits and error code for this cycle; timeout code wins
  always_comb begin
    status_set = 64'h0;
    status_set[ST_BUS_ERROR_OUT] = ev[EV_BUS_ERROR_OUT];
    status_set[ST_BUS_INIT_SIGNAL_DRV] = ev[EV_BUS_INIT_SIGNAL_DRV];
    status_set[ST_BUS_INIT_SIGNAL_RX] = ev[EV_BUS_INIT_SIGNAL_RX];
    status_set[ST_RESP_PAR] = ev[EV_RESP_PAR];
    status_set[ST_SPLIT_HARD] = ev[EV_SPLIT_HARD];
    status_set[ST_TIMEOUT] = ev[EV_TIMEOUT];
    if (ev[EV_TIMEOUT]) begin
      status_set[ST_CODE_WDOG] = 1'b1;
    end else if (ebl_event) begin
      status_set[ST_CODE_EBL] = 1'b1;
    end
  end

  // clear from software comes first so a same-cycle event survives it
  assign log_clear = apb_wr & hit_ctrl & pwdata[CTRL_CLEAR];
  assign status_base = log_clear ? STATUS_RESET : status_q;

  // a set timeout bit freezes bits and code until software clears the log
  always_comb begin
    status_d = status_base;
    if (!status_base[ST_TIMEOUT]) begin
      status_d = status_base | status_set;
      if (ev[EV_TIMEOUT]) begin
        status_d[ST_CODE_EBL] = 1'b0;
      end
    end
  end

  // only hardware events write the log; reserved bits never set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= STATUS_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  // apb phase and address decode
  assign apb_setup = psel & ~penable;
  assign apb_access = psel & penable;
  assign apb_wr = apb_access & pwrite & addr_ok;
  assign apb_rd = apb_access & ~pwrite & addr_ok;
  assign hit_status_lo = (paddr == OFF_STATUS_LO);
  assign hit_status_hi = (paddr == OFF_STATUS_HI);
  assign hit_ctrl = (paddr == OFF_CTRL);
  assign hit_wdog = (paddr == OFF_WDOG);
  assign hit_irq_stat = (paddr == OFF_IRQ_STAT);
  assign hit_irq_mask = (paddr == OFF_IRQ_MASK);
  assign addr_ok = hit_status_lo | hit_status_hi | hit_ctrl | hit_wdog | hit_irq_stat | hit_irq_mask;

  // zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = apb_access & ~addr_ok;

  // read mux; bits above each field read zero
  assign rd_mux = hit_status_lo ? status_q[31:0] :
                  hit_status_hi ? status_q[63:32] :
                  hit_ctrl ? {29'h0, ctrl_q} :
                  hit_wdog ? {17'h0, wd_count} :
                  hit_irq_stat ? {26'h0, irq_stat_q} :
                  hit_irq_mask ? {26'h0, irq_mask_q} : 32'h0;

  // writes return zero so stale read data never reappears
  assign prdata_d = pwrite ? 32'h0 : rd_mux;

  // read data latched in setup so the access phase can finish at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
    end else if (apb_setup) begin
      prdata_q <= prdata_d;
    end
  end

  assign prdata = prdata_q;

  // control and mask writes; the clear bit is a strobe and reads zero
  assign ctrl_d = (apb_wr & hit_ctrl) ? {pwdata[CTRL_BUS_INIT_SIGNAL_EN], pwdata[CTRL_RATIO_LSB +: 2]} : ctrl_q;
  assign irq_mask_d = (apb_wr & hit_irq_mask) ? pwdata[EV_W-1:0] : irq_mask_q;

  // a read clears only the bits it returned; a new event always wins
  assign irq_clr = (apb_rd & hit_irq_stat) ? prdata_q[EV_W-1:0] : '0;
  assign irq_stat_d = (irq_stat_q & ~irq_clr) | ev;

  // control register: ratio code and driver enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // interrupt mask, same layout as the interrupt status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= '0;
    end else begin
      irq_mask_q <= irq_mask_d;
    end
  end

  // sticky interrupt status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end

  // level interrupt while any unmasked event is pending
  assign irq = |(irq_stat_q & irq_mask_q);

endmodule // bel_top

// File: verif/bel_top_assertions.sv
// port-level checks for the bus error logger: pin timing and register read fields.
// assumes it is bound into bel_top and sees only its ports.
`timescale 1ns/1ps
module bel_top_assertions
  import bel_pkg::*;
#(
  parameter int unsigned PRESCALE_DIV = 128,
  parameter int unsigned WDOG_LIMIT = 32768
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [bel_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  // core side
  input wire logic bus_error_out_req,
  input wire logic bus_init_signal_req,
  // bus pins
  input wire logic bus_init_out,
  input wire logic bus_init_oe_n,
  input wire logic bus_error_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // read setup decode; prdata is latched at the setup edge
  wire rd_setup = psel && !penable && !pwrite;
  wire rd_lo = rd_setup && (paddr == OFF_STATUS_LO);
  wire rd_hi = rd_setup && (paddr == OFF_STATUS_HI);
  wire rd_wd = rd_setup && (paddr == OFF_WDOG);

  // cycles since bus init was last driven, saturating past the echo window
  logic [2:0] idle_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_q <= 3'h0;
    end else if (bus_init_out) begin
      idle_q <= 3'h0;
    end else if (idle_q != 3'h7) begin
      idle_q <= idle_q + 3'h1;
    end
  end

  a_bus_error_out_follow: assert property (bus_error_out == $past(bus_error_out_req))
    else $error("bus error pin does not follow its request");
  a_oe_drive: assert property (bus_init_oe_n == !bus_init_out)
    else $error("bus init enable disagrees with drive");
  a_bus_init_signal_start: assert property (bus_init_signal_req && idle_q == 3'h7 |=> bus_init_out)
    else $error("bus init request not driven");
  a_bus_init_signal_hold: assert property (bus_init_signal_req && bus_init_out |=> bus_init_out)
    else $error("bus init dropped while requested");
  a_lo_reserved: assert property (rd_lo |=> !prdata[31])
    else $error("status bit 31 not zero");
  a_hi_reserved: assert property (rd_hi |=> prdata[2:0] == 3'h0)
    else $error("status bits 32 to 34 not zero");
  a_wdog_width: assert property (rd_wd |=> prdata[31:15] == 17'h0)
    else $error("watchdog count wider than 15 bits");
  a_code_only: assert property (rd_lo |=> prdata[15:0] inside {16'h0, 16'h0400, 16'h0800})
    else $error("error code field malformed");
endmodule // bel_top_assertions

// File: verif/bel_bus_agent.sv
// system bus agent: answers responses and drives bus init toward the logger.
// assumes bench commands arrive one pclk ahead of the pins.
`timescale 1ns/1ps
module bel_bus_agent (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench commands
  input wire logic resp_go,
  input wire logic [2:0] resp_code,
  input wire logic resp_bad,
  input wire logic bus_init_signal_go,
  // bus pins
  output logic response_valid_in,
  output logic [2:0] response_status_in,
  output logic response_parity_in,
  output logic agent_bus_init_signal
);
  // idle status lines toggle so a stale code never looks stable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      response_valid_in <= 1'b0;
      response_status_in <= 3'h0;
      response_parity_in <= 1'b0;
      agent_bus_init_signal <= 1'b0;
    end else begin
      agent_bus_init_signal <= bus_init_signal_go;
      response_valid_in <= resp_go;
      response_status_in <= resp_go ? resp_code : ~response_status_in;
      response_parity_in <= resp_go ? (^resp_code) ^ resp_bad : ~response_parity_in;
    end
  end
endmodule // bel_bus_agent

// File: verif/tb_bus_error_status_logger.sv
// self-checking bench for the bus error logger over apb.
// assumes shortened watchdog parameters; bus init pin is a wired-or of both drivers.
`timescale 1ns/1ps
module tb_bus_error_status_logger;
  import bel_pkg::*;
  localparam int unsigned PDIV = 4;
  localparam int unsigned WLIM = 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, irq;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic uop_retire, core_exception, bus_error_out_req, bus_init_signal_req, split_access;
  logic bus_init_in, bus_init_out, bus_init_oe_n, bus_error_out, agent_bus_init_signal;
  logic response_valid_in, response_parity_in, resp_go, resp_bad, bus_init_signal_go;
  logic [2:0] response_status_in, resp_code;
  int n_fail = 0, n_tests = 0, cyc = 0, last_bi = 0, t0, k, dv;
  logic [11:0] offs [6] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014};
  logic [3:0] rcode [4] = '{4'h2, 4'hd, 4'h1, 4'h1};
  logic [31:0] rexp [4] = '{32'h0, 32'h10, 32'h0, 32'h20};

  // wire level of the bus init pin
  assign bus_init_in = agent_bus_init_signal | (bus_init_oe_n === 1'b0 && bus_init_out === 1'b1);

  bel_top #(.PRESCALE_DIV(PDIV), .WDOG_LIMIT(WLIM)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .uop_retire(uop_retire), .core_exception(core_exception), .bus_error_out_req(bus_error_out_req),
    .bus_init_signal_req(bus_init_signal_req), .split_access(split_access), .bus_init_in(bus_init_in), .bus_init_out(bus_init_out),
    .bus_init_oe_n(bus_init_oe_n), .bus_error_out(bus_error_out), .response_valid_in(response_valid_in),
    .response_status_in(response_status_in), .response_parity_in(response_parity_in), .irq(irq));
  bel_bus_agent u_agent (.pclk(pclk), .presetn(presetn), .resp_go(resp_go), .resp_code(resp_code),
    .resp_bad(resp_bad), .bus_init_signal_go(bus_init_signal_go), .response_valid_in(response_valid_in),
    .response_status_in(response_status_in), .response_parity_in(response_parity_in), .agent_bus_init_signal(agent_bus_init_signal));

  // clock and cycle bookkeeping
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (bus_init_out === 1'b1) last_bi <= cyc;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_rng(input string name, input int lo, input int hi, input int got);
    n_tests++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("[ERR] %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask
  // one apb transfer, entered just after a rising edge; idles a cycle after
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        n_fail++;
        tally_and_finish();
      end
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask
  task automatic pulse_bus_error_out();
    bus_error_out_req <= 1'b1;
    @(posedge pclk);
    bus_error_out_req <= 1'b0;
    @(posedge pclk);
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, core_exception} = '0;
    uop_retire = 1'b1; // watchdog held clear until its own scenarios
    {bus_error_out_req, bus_init_signal_req, split_access, resp_go, resp_code, resp_bad, bus_init_signal_go} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 6; i++) rdchk("reset value", offs[i], 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    // bus error with the event masked, then unmasked
    pulse_bus_error_out();
    chk("bus error pin", 32'h1, {31'h0, bus_error_out});
    rdchk("status lo bus_error_out", OFF_STATUS_LO, 32'h2000_0800);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, OFF_IRQ_MASK, 32'h3f);
    chk("irq raised", 32'h1, {31'h0, irq});
    rdchk("irq status", OFF_IRQ_STAT, 32'h1);
    chk("irq cleared", 32'h0, {31'h0, irq});
    apb(1'b1, OFF_STATUS_LO, 32'hffff_ffff);
    apb(1'b1, OFF_STATUS_HI, 32'hffff_ffff);
    rdchk("status lo write", OFF_STATUS_LO, 32'h2000_0800);
    rdchk("status hi write", OFF_STATUS_HI, 32'h0);
    apb(1'b1, OFF_CTRL, 32'h8);
    // own bus init drive is logged as driven, not as received
    bus_init_signal_req <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("bus init drive", 32'h1, {31'h0, bus_init_out & ~bus_init_oe_n});
    bus_init_signal_req <= 1'b0;
    repeat (8) @(posedge pclk);
    rdchk("status lo bus_init_signal", OFF_STATUS_LO, 32'h4000_0800);
    rdchk("status hi own bus_init_signal", OFF_STATUS_HI, 32'h0);
    rdchk("irq bus_init_signal drive", OFF_IRQ_STAT, 32'h2);
    apb(1'b1, OFF_CTRL, 32'h8);
    bus_init_signal_go <= 1'b1;
    repeat (4) @(posedge pclk);
    bus_init_signal_go <= 1'b0;
    repeat (4) @(posedge pclk);
    rdchk("status hi bus_init_signal rx", OFF_STATUS_HI, 32'h8);
    rdchk("irq bus_init_signal rx", OFF_IRQ_STAT, 32'h4);
    apb(1'b1, OFF_CTRL, 32'h8);
    // responses: {bad parity, code}, split only on the last
    for (int i = 0; i < 4; i++) begin
      split_access <= (i == 3);
      {resp_bad, resp_code} <= rcode[i];
      resp_go <= 1'b1;
      @(posedge pclk);
      resp_go <= 1'b0;
      repeat (5) @(posedge pclk);
      split_access <= 1'b0;
      rdchk("status hi response", OFF_STATUS_HI, rexp[i]);
      rdchk("irq response", OFF_IRQ_STAT, rexp[i] >> 1);
      apb(1'b1, OFF_CTRL, 32'h8);
    end
    // watchdog disabled, then held clear by retire and by exception
    uop_retire <= 1'b0;
    repeat (80) @(posedge pclk);
    rdchk("no timeout disabled", OFF_STATUS_HI, 32'h0);
    for (int i = 0; i < 2; i++) begin
      uop_retire <= (i == 0);
      core_exception <= (i == 1);
      apb(1'b1, OFF_CTRL, 32'h4);
      repeat (80) @(posedge pclk);
      rdchk("count held clear", OFF_WDOG, 32'h0);
      rdchk("no timeout held", OFF_STATUS_HI, 32'h0);
      uop_retire <= 1'b1;
      core_exception <= 1'b0;
      apb(1'b1, OFF_CTRL, 32'h8);
    end
    // expiry time for each bus clock ratio
    for (int c = 0; c < 4; c++) begin
      dv = (c == 3) ? 4 : c + 2;
      apb(1'b1, OFF_CTRL, 32'h4 | c);
      uop_retire <= 1'b0;
      t0 = cyc;
      k = 0;
      do begin
        apb(1'b0, OFF_STATUS_HI, 32'h0);
        k++;
      end while (rd[6] !== 1'b1 && k < 100);
      chk_rng("expiry cycles", (PDIV * WLIM - 1) * dv, PDIV * WLIM * dv + 12, cyc - t0);
      chk_rng("watchdog bus init", t0, cyc, last_bi);
      rdchk("timeout code", OFF_STATUS_LO, 32'h4000_0400);
      pulse_bus_error_out();
      repeat (4) @(posedge pclk);
      apb(1'b0, OFF_STATUS_LO, 32'h0);
      chk("frozen log", 32'h0000_0400, rd & 32'h2000_ffff);
      uop_retire <= 1'b1;
      apb(1'b1, OFF_CTRL, 32'h8);
    end
    tally_and_finish();
  end
endmodule // tb_bus_error_status_logger

bind bel_top bel_top_assertions #(.PRESCALE_DIV(PRESCALE_DIV), .WDOG_LIMIT(WDOG_LIMIT)) u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .bus_error_out_req(bus_error_out_req), .bus_init_signal_req(bus_init_signal_req), .bus_init_out(bus_init_out), .bus_init_oe_n(bus_init_oe_n),
  .bus_error_out(bus_error_out));
